/* inc/can_rx_pkg.sv */
// Purpose: Shared constants for the CAN receive buffer and filter block.
// Assumes: Byte-wide registers, each on its own aligned APB word.
// Notes: Identifiers are held as 29 bits, standard part in bits 28..18.
package can_rx_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ID_W = 29;
  localparam int N_FILT = 2;
  localparam int N_DATA = 8;
  localparam int IRQ_W = 3;
  localparam int SID_LSB = 18;
  localparam int IDH_LSB = 21;
  localparam int EIDH_LSB = 8;
  localparam int EXTU_LSB = 16;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IDH = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IDL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EIDH = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_EIDL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DLC = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DATA = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_REC = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_FILT = 8'h40;
  localparam logic [ADDR_W-1:0] FILT_STRIDE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h60;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ST = 8'h70;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MSK = 8'h74;
  localparam logic [ADDR_W-1:0] WORD_STRIDE = 8'h04;
  localparam int SUB_IDH = 0;
  localparam int SUB_IDL = 1;
  localparam int SUB_EIDH = 2;
  localparam int SUB_EIDL = 3;

  localparam int CTRL_FULL_BIT = 7;
  localparam int CTRL_MODE_LSB = 5;
  localparam int CTRL_RTR_BIT = 3;
  localparam int CTRL_HIT_BIT = 0;
  localparam int IDL_SRR_BIT = 4;
  localparam int IDL_EXT_BIT = 3;
  localparam int DLC_RTR_BIT = 6;

  localparam int IRQ_STORED = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_PASSIVE = 2;

  localparam logic [3:0] DLC_MAX = 4'h8;
  localparam logic [7:0] REC_PASSIVE_LIMIT = 8'h7F;
  localparam logic [7:0] REC_RESTART = 8'h77;
  localparam logic [7:0] REC_STEP_SMALL = 8'h01;
  localparam logic [7:0] REC_STEP_LARGE = 8'h08;
  localparam logic [7:0] REC_TOP = 8'hFF;

  typedef enum logic [1:0] {
    MODE_ALL_VALID = 2'h0,
    MODE_STD_ONLY = 2'h1,
    MODE_EXT_ONLY = 2'h2,
    MODE_ANY = 2'h3
  } rx_mode_t;
endpackage

/* logic/rx_filter_match.sv */
// Purpose: Compares one frame identifier with one filter under the mask.
// Assumes: Identifiers aligned with standard bits in 28..18.
// Notes: Purely combinational.
`timescale 1ns/100ps
module rx_filter_match (
  // Filter and mask setup
  input wire logic [can_rx_pkg::ID_W-1:0] filt_id_i,
  input wire logic filt_ext_i,
  input wire logic [can_rx_pkg::ID_W-1:0] mask_i,
  // Frame under test
  input wire logic [can_rx_pkg::ID_W-1:0] frame_id_i,
  input wire logic frame_ext_i,
  // Result
  output logic hit_o
);
  import can_rx_pkg::*;
  logic [ID_W-1:0] eff_mask;
  logic [ID_W-1:0] diff;

  // Standard frames use only the eleven upper mask bits.
  assign eff_mask = frame_ext_i ? mask_i :
    {mask_i[ID_W-1:SID_LSB], {SID_LSB{1'b0}}};
  assign diff = (filt_id_i ^ frame_id_i) & eff_mask;
  assign hit_o = (filt_ext_i == frame_ext_i) && (diff == '0);
endmodule

/* logic/rx_error_counter.sv */
// Purpose: Receive error counter and its error-passive indication.
// Assumes: Error and success events are one-cycle pulses.
// Notes: Counter saturates at its top value.
`timescale 1ns/100ps
module rx_error_counter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Events from the protocol engine
  input wire logic err_small_i,
  input wire logic err_large_i,
  input wire logic rx_ok_i,
  // State
  output logic [7:0] count_o,
  output logic passive_o
);
  import can_rx_pkg::*;
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic [8:0] sum;
  logic [7:0] step;

  always_comb begin
    step = err_large_i ? REC_STEP_LARGE : REC_STEP_SMALL;
    sum = {1'b0, count_ff} + {1'b0, step};
    nxt_count = count_ff;
    if (err_small_i || err_large_i) begin
      nxt_count = sum[8] ? REC_TOP : sum[7:0];
    end else if (rx_ok_i) begin
      if (count_ff > REC_PASSIVE_LIMIT) begin
        nxt_count = REC_RESTART;
      end else if (count_ff != '0) begin
        nxt_count = count_ff - REC_STEP_SMALL;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // No bus-off output exists here; only passive is derived.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      passive_o <= 1'b0;
    end else begin
      passive_o <= nxt_count > REC_PASSIVE_LIMIT;
    end
  end

  assign count_o = count_ff;
endmodule

/* logic/can_rx_buffer.sv */
// Purpose: CAN receive buffer with acceptance filters and error counter.
// Assumes: Protocol engine delivers one decoded frame per rx_valid_i.
// Notes: Registers are byte wide on APB words; one wait-free access.
// What this block does
// - Low byte bits 7-5 hold identifier 20..18.
// - Bit 4 zero if extended, else remote copy.
// - Bit 3 shows extended frame.
// - Extended identifier split over four bytes.
// - Length bit 6 remote request, bit 7 zero.
// - Length bits 5 and 4 read zero.
// - Length code counts bytes; above eight means eight.
// - Eight data byte registers, byte 0 first.
// - Eight-bit read-only receive error counter.
// - Counter above 127 gives error-passive.
// - Counter never causes bus-off.
// - Filter high byte is identifier 28..21.
// - Filter low byte and two bytes hold rest.
// - Filter extended enable picks frame type.
// - Mask covers eleven or twenty-nine bits.
// - Mask low byte bits 4-2 read zero.
// - Full flag set on store, software clears.
// - Mode selects which frames are stored.
`timescale 1ns/100ps
module can_rx_buffer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [can_rx_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [can_rx_pkg::DATA_W-1:0] pwdata_i,
  output logic [can_rx_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Decoded frame from the protocol engine
  input wire logic rx_valid_i,
  input wire logic [can_rx_pkg::ID_W-1:0] rx_id_i,
  input wire logic rx_ext_i,
  input wire logic rx_rtr_i,
  input wire logic [3:0] rx_dlc_i,
  input wire logic [63:0] rx_data_i,
  input wire logic rx_bad_i,
  // Receive error events
  input wire logic rx_err_small_i,
  input wire logic rx_err_large_i,
  input wire logic rx_ok_i,
  // Status
  output logic err_passive_o,
  output logic irq_o
);
  import can_rx_pkg::*;

  function automatic logic [ADDR_W-1:0] slot_addr(
    input logic [ADDR_W-1:0] base,
    input int idx,
    input logic [ADDR_W-1:0] stride
  );
    slot_addr = base + ADDR_W'(idx) * stride;
  endfunction

  logic [ID_W-1:0] buf_id_ff;
  logic buf_ext_ff;
  logic buf_rtr_ff;
  logic [3:0] buf_dlc_ff;
  logic [7:0] buf_data_ff [N_DATA];
  logic buf_full_ff;
  logic buf_hit_ff;
  rx_mode_t mode_ff;
  logic [ID_W-1:0] filt_id_ff [N_FILT];
  logic filt_ext_ff [N_FILT];
  logic [ID_W-1:0] mask_ff;
  logic [IRQ_W-1:0] irq_st_ff;
  logic [IRQ_W-1:0] irq_msk_ff;
  logic passive_prev_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic [7:0] nxt_rdata;
  logic nxt_err;
  logic [N_FILT-1:0] hits;
  logic [7:0] rec_count;
  logic passive;
  logic type_ok;
  logic accept;
  logic store;
  logic wr_en;
  logic [3:0] nbytes;
  logic [7:0] wbyte;

  assign wr_en = psel_i && penable_i && pready_ff && pwrite_i;
  assign wbyte = pwdata_i[7:0];

  genvar g;
  generate
    for (g = 0; g < N_FILT; g++) begin : g_filt
      rx_filter_match u_match (
        .filt_id_i(filt_id_ff[g]),
        .filt_ext_i(filt_ext_ff[g]),
        .mask_i(mask_ff),
        .frame_id_i(rx_id_i),
        .frame_ext_i(rx_ext_i),
        .hit_o(hits[g])
      );
    end
  endgenerate

  rx_error_counter u_rec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .err_small_i(rx_err_small_i),
    .err_large_i(rx_err_large_i),
    .rx_ok_i(rx_ok_i),
    .count_o(rec_count),
    .passive_o(passive)
  );

  // Frame type must suit the mode; mode any also takes erroneous frames.
  always_comb begin
    unique case (mode_ff)
      MODE_STD_ONLY: type_ok = !rx_ext_i;
      MODE_EXT_ONLY: type_ok = rx_ext_i;
      default: type_ok = 1'b1;
    endcase
  end

  assign accept = (mode_ff == MODE_ANY) ||
    (!rx_bad_i && type_ok && (hits != '0));
  assign store = rx_valid_i && accept && !buf_full_ff;
  assign nbytes = (rx_dlc_i > DLC_MAX) ? DLC_MAX : rx_dlc_i;

  // Captured frame; software may also overwrite the buffer bytes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_id_ff <= '0;
      buf_ext_ff <= 1'b0;
      buf_rtr_ff <= 1'b0;
      buf_dlc_ff <= '0;
      buf_hit_ff <= 1'b0;
    end else if (store) begin
      buf_id_ff <= rx_id_i;
      buf_ext_ff <= rx_ext_i;
      buf_rtr_ff <= rx_rtr_i;
      buf_dlc_ff <= rx_dlc_i;
      buf_hit_ff <= !hits[0] && hits[1];
    end else if (wr_en) begin
      unique case (paddr_i)
        OFF_IDH: buf_id_ff[ID_W-1:IDH_LSB] <= wbyte;
        OFF_IDL: begin
          buf_id_ff[IDH_LSB-1:SID_LSB] <= wbyte[7:5];
          buf_ext_ff <= wbyte[IDL_EXT_BIT];
          buf_id_ff[SID_LSB-1:EXTU_LSB] <= wbyte[1:0];
        end
        OFF_EIDH: buf_id_ff[EXTU_LSB-1:EIDH_LSB] <= wbyte;
        OFF_EIDL: buf_id_ff[EIDH_LSB-1:0] <= wbyte;
        OFF_DLC: begin
          buf_rtr_ff <= wbyte[DLC_RTR_BIT];
          buf_dlc_ff <= wbyte[3:0];
        end
        default: buf_hit_ff <= buf_hit_ff;
      endcase
    end
  end

  // Data bytes beyond the length code are cleared on capture.
  always_ff @(posedge clk_i) begin
    for (int m = 0; m < N_DATA; m++) begin
      if (rst_i) begin
        buf_data_ff[m] <= '0;
      end else if (store) begin
        buf_data_ff[m] <= (m < int'(nbytes)) ? rx_data_i[8*m +: 8]
          : 8'h00;
      end else if (wr_en && paddr_i == slot_addr(OFF_DATA, m, WORD_STRIDE)) begin
        buf_data_ff[m] <= wbyte;
      end
    end
  end

  // A new frame wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_full_ff <= 1'b0;
    end else if (store) begin
      buf_full_ff <= 1'b1;
    end else if (wr_en && paddr_i == OFF_CTRL && wbyte[CTRL_FULL_BIT]) begin
      buf_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= MODE_ALL_VALID;
    end else if (wr_en && paddr_i == OFF_CTRL) begin
      mode_ff <= rx_mode_t'(wbyte[CTRL_MODE_LSB +: 2]);
    end
  end

  // Filter registers.
  always_ff @(posedge clk_i) begin
    for (int f = 0; f < N_FILT; f++) begin
      if (rst_i) begin
        filt_id_ff[f] <= '0;
        filt_ext_ff[f] <= 1'b0;
      end else if (wr_en) begin
        if (paddr_i == slot_addr(OFF_FILT, f, FILT_STRIDE) + WORD_STRIDE *
            ADDR_W'(SUB_IDH)) begin
          filt_id_ff[f][ID_W-1:IDH_LSB] <= wbyte;
        end
        if (paddr_i == slot_addr(OFF_FILT, f, FILT_STRIDE) + WORD_STRIDE *
            ADDR_W'(SUB_IDL)) begin
          filt_id_ff[f][IDH_LSB-1:SID_LSB] <= wbyte[7:5];
          filt_ext_ff[f] <= wbyte[IDL_EXT_BIT];
          filt_id_ff[f][SID_LSB-1:EXTU_LSB] <= wbyte[1:0];
        end
        if (paddr_i == slot_addr(OFF_FILT, f, FILT_STRIDE) + WORD_STRIDE *
            ADDR_W'(SUB_EIDH)) begin
          filt_id_ff[f][EXTU_LSB-1:EIDH_LSB] <= wbyte;
        end
        if (paddr_i == slot_addr(OFF_FILT, f, FILT_STRIDE) + WORD_STRIDE *
            ADDR_W'(SUB_EIDL)) begin
          filt_id_ff[f][EIDH_LSB-1:0] <= wbyte;
        end
      end
    end
  end

  // Mask registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= '0;
    end else if (wr_en) begin
      if (paddr_i == slot_addr(OFF_MASK, SUB_IDH, WORD_STRIDE)) begin
        mask_ff[ID_W-1:IDH_LSB] <= wbyte;
      end
      if (paddr_i == slot_addr(OFF_MASK, SUB_IDL, WORD_STRIDE)) begin
        mask_ff[IDH_LSB-1:SID_LSB] <= wbyte[7:5];
        mask_ff[SID_LSB-1:EXTU_LSB] <= wbyte[1:0];
      end
      if (paddr_i == slot_addr(OFF_MASK, SUB_EIDH, WORD_STRIDE)) begin
        mask_ff[EXTU_LSB-1:EIDH_LSB] <= wbyte;
      end
      if (paddr_i == slot_addr(OFF_MASK, SUB_EIDL, WORD_STRIDE)) begin
        mask_ff[EIDH_LSB-1:0] <= wbyte;
      end
    end
  end

  // Sticky interrupt status; a new event wins over the write-one clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_ff <= '0;
      passive_prev_ff <= 1'b0;
    end else begin
      passive_prev_ff <= passive;
      irq_st_ff <= (irq_st_ff & ~((wr_en && paddr_i == OFF_IRQ_ST) ?
        wbyte[IRQ_W-1:0] : {IRQ_W{1'b0}})) |
        {passive && !passive_prev_ff,
         rx_valid_i && accept && buf_full_ff,
         store};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_msk_ff <= '0;
    end else if (wr_en && paddr_i == OFF_IRQ_MSK) begin
      irq_msk_ff <= wbyte[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      err_passive_o <= 1'b0;
    end else begin
      irq_o <= (irq_st_ff & irq_msk_ff) != '0;
      err_passive_o <= passive;
    end
  end

  // Read decode; unmapped addresses answer with an error.
  always_comb begin
    nxt_rdata = '0;
    nxt_err = 1'b0;
    unique case (paddr_i)
      OFF_CTRL: nxt_rdata = {buf_full_ff, mode_ff, 1'b0, buf_rtr_ff, 2'b00,
        buf_hit_ff};
      OFF_IDH: nxt_rdata = buf_id_ff[ID_W-1:IDH_LSB];
      OFF_IDL: nxt_rdata = {buf_id_ff[IDH_LSB-1:SID_LSB],
        buf_ext_ff ? 1'b0 : buf_rtr_ff, buf_ext_ff, 1'b0,
        buf_id_ff[SID_LSB-1:EXTU_LSB]};
      OFF_EIDH: nxt_rdata = buf_id_ff[EXTU_LSB-1:EIDH_LSB];
      OFF_EIDL: nxt_rdata = buf_id_ff[EIDH_LSB-1:0];
      OFF_DLC: nxt_rdata = {1'b0, buf_rtr_ff, 2'b00, buf_dlc_ff};
      OFF_REC: nxt_rdata = rec_count;
      OFF_IRQ_ST: nxt_rdata = {{(8-IRQ_W){1'b0}}, irq_st_ff};
      OFF_IRQ_MSK: nxt_rdata = {{(8-IRQ_W){1'b0}}, irq_msk_ff};
      default: nxt_err = 1'b1;
    endcase
    for (int m = 0; m < N_DATA; m++) begin
      if (paddr_i == slot_addr(OFF_DATA, m, WORD_STRIDE)) begin
        nxt_rdata = buf_data_ff[m];
        nxt_err = 1'b0;
      end
    end
    for (int s = 0; s < 4; s++) begin
      if (paddr_i == slot_addr(OFF_MASK, s, WORD_STRIDE)) begin
        nxt_err = 1'b0;
        unique case (s)
          SUB_IDH: nxt_rdata = mask_ff[ID_W-1:IDH_LSB];
          SUB_IDL: nxt_rdata = {mask_ff[IDH_LSB-1:SID_LSB], 3'b000,
            mask_ff[SID_LSB-1:EXTU_LSB]};
          SUB_EIDH: nxt_rdata = mask_ff[EXTU_LSB-1:EIDH_LSB];
          default: nxt_rdata = mask_ff[EIDH_LSB-1:0];
        endcase
      end
      for (int f = 0; f < N_FILT; f++) begin
        if (paddr_i == slot_addr(OFF_FILT, f, FILT_STRIDE) + WORD_STRIDE *
            ADDR_W'(s)) begin
          nxt_err = 1'b0;
          unique case (s)
            SUB_IDH: nxt_rdata = filt_id_ff[f][ID_W-1:IDH_LSB];
            SUB_IDL: nxt_rdata = {filt_id_ff[f][IDH_LSB-1:SID_LSB], 1'b0,
              filt_ext_ff[f], 1'b0, filt_id_ff[f][SID_LSB-1:EXTU_LSB]};
            SUB_EIDH: nxt_rdata = filt_id_ff[f][EXTU_LSB-1:EIDH_LSB];
            default: nxt_rdata = filt_id_ff[f][EIDH_LSB-1:0];
          endcase
        end
      end
    end
  end

  // Answer in the first access cycle; data captured in the setup cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= psel_i && !penable_i;
      pslverr_ff <= psel_i && !penable_i && nxt_err;
      if (psel_i && !penable_i && !pwrite_i) begin
        prdata_ff <= {{(DATA_W-8){1'b0}}, nxt_rdata};
      end
    end
  end

  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign prdata_o = prdata_ff;
endmodule

/* bench/can_rx_buffer_chk.sv */
// Purpose: Port checks for the CAN receive buffer block.
// Assumes: Zero-wait APB slave, one clock.
// Notes: Bound from the bench top.
`timescale 1ns/100ps
module can_rx_buffer_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Events and status
  input wire logic rx_valid_i,
  input wire logic rx_err_small_i,
  input wire logic rx_err_large_i,
  input wire logic rx_ok_i,
  input wire logic err_passive_o,
  input wire logic irq_o
);
  import can_rx_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic rd_req;
  assign rd_req = psel_i & ~penable_i & ~pwrite_i;
  AST_READY_NEXT: assert property (psel_i && !penable_i |=> pready_o)
    else $error("No ready after setup.");
  AST_READY_ONE: assert property (pready_o |=> !pready_o)
    else $error("Ready held too long.");
  AST_SLVERR: assert property (pslverr_o |-> pready_o)
    else $error("Error without ready.");
  AST_PASSIVE_RISE: assert property (
    $rose(err_passive_o) |-> $past(rx_err_small_i || rx_err_large_i, 2))
    else $error("Passive entered without an error.");
  AST_PASSIVE_FALL: assert property (
    $fell(err_passive_o) |-> $past(rx_ok_i, 2) || $past(rst_i, 2))
    else $error("Passive left without a good frame.");
  AST_REC_TOP: assert property (
    rd_req && paddr_i == OFF_REC |=> prdata_o[7] == $past(err_passive_o))
    else $error("Count top bit and passive disagree.");
  AST_IDL_SRR: assert property (
    rd_req && paddr_i == OFF_IDL |=> !(prdata_o[3] && prdata_o[4]))
    else $error("Substitute bit set on extended frame.");
  AST_DLC_ZERO: assert property (
    rd_req && paddr_i == OFF_DLC |=> (prdata_o[7:4] & 4'hB) == 4'h0)
    else $error("Length reserved bits not zero.");
  AST_MASK_LOW: assert property (
    rd_req && paddr_i == OFF_MASK + WORD_STRIDE |=> prdata_o[4:2] == 3'h0)
    else $error("Mask low bits 4-2 not zero.");
  cover property (rx_valid_i ##2 irq_o);
  cover property ($rose(err_passive_o));
  cover property (pslverr_o);
endmodule

/* bench/can_node_model.sv */
// Purpose: Stand-in for remote nodes and the protocol engine.
// Assumes: Frames and error events are one-cycle pulses.
// Notes: Idle fields are inverted so stale values cannot pass.
`timescale 1ns/100ps
module can_node_model (
  // Clock
  input wire logic clk_i,
  // Decoded frame and events
  output logic rx_valid_o = 1'b0,
  output logic [28:0] rx_id_o = 29'h0,
  output logic rx_ext_o = 1'b0,
  output logic rx_rtr_o = 1'b0,
  output logic [3:0] rx_dlc_o = 4'h0,
  output logic [63:0] rx_data_o = 64'h0,
  output logic rx_bad_o = 1'b0,
  output logic err_small_o = 1'b0,
  output logic err_large_o = 1'b0,
  output logic ok_o = 1'b0
);
  task automatic send(input logic [28:0] id, input logic ext, rtr,
                      input logic [3:0] dlc, input logic [63:0] d,
                      input logic bad);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_id_o <= id;
    rx_ext_o <= ext;
    rx_rtr_o <= rtr;
    rx_dlc_o <= dlc;
    rx_data_o <= d;
    rx_bad_o <= bad;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_id_o <= ~id;
    rx_ext_o <= ~ext;
    rx_rtr_o <= ~rtr;
    rx_dlc_o <= ~dlc;
    rx_data_o <= ~d;
    rx_bad_o <= ~bad;
  endtask
  task automatic evt(input int k);
    @(posedge clk_i);
    err_small_o <= (k == 0);
    err_large_o <= (k == 1);
    ok_o <= (k == 2);
    @(posedge clk_i);
    err_small_o <= 1'b0;
    err_large_o <= 1'b0;
    ok_o <= 1'b0;
  endtask
endmodule

/* bench/test_can_rx_buffer.sv */
// Purpose: Self-checking bench for the CAN receive buffer block.
// Assumes: Zero-wait APB slave; frames come from the node model.
// Notes: Register map as in the shared package.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_can_rx_buffer;
  import can_rx_pkg::*;
  localparam logic [28:0] SID_A = {11'h123, 18'h0};
  localparam logic [28:0] EXT_B = 29'h1ABCDEF5;
  localparam logic [63:0] DAT = 64'h8877665544332211;
  localparam logic [7:0] MSK_LO = OFF_MASK + WORD_STRIDE;
  localparam logic [7:0] F1 = OFF_FILT + FILT_STRIDE;
  logic clk_i;
  logic rst_i;
  logic psel_i, penable_i, pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, err_passive_o, irq_o, er;
  logic rx_valid_i, rx_ext_i, rx_rtr_i, rx_bad_i;
  logic rx_err_small_i, rx_err_large_i, rx_ok_i;
  logic [28:0] rx_id_i;
  logic [3:0] rx_dlc_i;
  logic [63:0] rx_data_i;
  logic md_bad [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic md_full [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int error_cnt = 0;
  int checks = 0;
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  can_rx_buffer uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i), .rx_id_i(rx_id_i),
    .rx_ext_i(rx_ext_i), .rx_rtr_i(rx_rtr_i), .rx_dlc_i(rx_dlc_i),
    .rx_data_i(rx_data_i), .rx_bad_i(rx_bad_i),
    .rx_err_small_i(rx_err_small_i), .rx_err_large_i(rx_err_large_i),
    .rx_ok_i(rx_ok_i), .err_passive_o(err_passive_o), .irq_o(irq_o));
  can_node_model node (.clk_i(clk_i), .rx_valid_o(rx_valid_i),
    .rx_id_o(rx_id_i), .rx_ext_o(rx_ext_i), .rx_rtr_o(rx_rtr_i),
    .rx_dlc_o(rx_dlc_i), .rx_data_o(rx_data_i), .rx_bad_o(rx_bad_i),
    .err_small_o(rx_err_small_i), .err_large_o(rx_err_large_i),
    .ok_o(rx_ok_i));
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, string n);
    apb(1'b0, a, 8'h00);
    `CHK(n, {24'h0, e}, rd)
  endtask
  task automatic fullchk(input logic e);
    apb(1'b0, OFF_CTRL, 8'h00);
    `CHK("full", e, rd[7])
  endtask
  task automatic settle();
    repeat (2) @(negedge clk_i);
  endtask
  function automatic logic [31:0] idb(logic [28:0] id, logic x, logic s);
    return {id[28:21], id[20:18], s, x, 1'b0, id[17:0]};
  endfunction
  task automatic setid(input logic [7:0] b, input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      wr(b + 8'(4 * i), v[31 - 8 * i -: 8]);
    end
  endtask
  task automatic chkbuf(input logic [28:0] id, input logic x, r,
                        input logic [3:0] dlc, input logic hit);
    logic [31:0] v;
    v = idb(id, x, r & ~x);
    for (int i = 0; i < 4; i++) begin
      rdchk(OFF_IDH + 8'(4 * i), v[31 - 8 * i -: 8], "id");
    end
    rdchk(OFF_DLC, {1'b0, r, 2'b00, dlc}, "dlc");
    for (int m = 0; m < 8; m++) begin
      rdchk(OFF_DATA + 8'(4 * m), (m < dlc) ? DAT[8 * m +: 8] : 8'h00, "d");
    end
    rdchk(OFF_CTRL, {4'h8, r, 2'b00, hit}, "ctrl");
  endtask
  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end
  initial begin
    rst_i <= 1'b1;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    pwrite_i <= 1'b0;
    paddr_i <= 8'h00;
    pwdata_i <= 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(OFF_CTRL, 8'h00, "ctrl");
    wr(OFF_REC, 8'h55);
    rdchk(OFF_REC, 8'h00, "rec");
    apb(1'b0, 8'hFC, 8'h00);
    `CHK("slverr", 1'b1, er)
    wr(MSK_LO, 8'hFF);
    rdchk(MSK_LO, 8'hE3, "mask");
    wr(OFF_FILT + WORD_STRIDE, 8'hFF);
    rdchk(OFF_FILT + WORD_STRIDE, 8'hEB, "filt");
    setid(OFF_MASK, idb(29'h1FFFFFFF, 1'b0, 1'b0));
    setid(OFF_FILT, idb(SID_A, 1'b0, 1'b0));
    setid(F1, idb(EXT_B, 1'b1, 1'b0));
    wr(OFF_IRQ_MSK, 8'h07);
    node.send(SID_A, 1'b0, 1'b1, 4'h8, DAT, 1'b0);
    settle();
    `CHK("irq", 1'b1, irq_o)
    chkbuf(SID_A, 1'b0, 1'b1, 4'h8, 1'b0);
    node.send(SID_A, 1'b0, 1'b0, 4'h2, DAT, 1'b0);
    rdchk(OFF_IRQ_ST, 8'h03, "irq st");
    rdchk(OFF_DLC, 8'h48, "kept");
    wr(OFF_IRQ_ST, 8'h07);
    wr(OFF_CTRL, 8'h80);
    fullchk(1'b0);
    `CHK("irq", 1'b0, irq_o)
    node.send(EXT_B, 1'b1, 1'b1, 4'hF, DAT, 1'b0);
    chkbuf(EXT_B, 1'b1, 1'b1, 4'hF, 1'b1);
    wr(OFF_CTRL, 8'h80);
    node.send(SID_A, 1'b1, 1'b0, 4'h1, DAT, 1'b0);
    node.send({11'h122, 18'h0}, 1'b0, 1'b0, 4'h1, DAT, 1'b0);
    fullchk(1'b0);
    wr(MSK_LO, 8'hC3);
    node.send({11'h122, 18'h0}, 1'b0, 1'b0, 4'h1, DAT, 1'b0);
    fullchk(1'b1);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, 8'h80 | 8'(m << 5));
      node.send(SID_A, 1'b0, 1'b0, 4'h0, DAT, md_bad[m]);
      fullchk(md_full[m]);
    end
    wr(OFF_IRQ_ST, 8'h07);
    node.evt(0);
    rdchk(OFF_REC, 8'h01, "rec");
    node.evt(2);
    rdchk(OFF_REC, 8'h00, "rec");
    repeat (15) node.evt(1);
    repeat (7) node.evt(0);
    rdchk(OFF_REC, 8'h7F, "rec");
    `CHK("passive", 1'b0, err_passive_o)
    node.evt(0);
    rdchk(OFF_REC, 8'h80, "rec");
    `CHK("passive", 1'b1, err_passive_o)
    repeat (16) node.evt(1);
    wr(OFF_IRQ_MSK, 8'h00);
    rdchk(OFF_IRQ_ST, 8'h04, "irq st");
    `CHK("irq", 1'b0, irq_o)
    wr(OFF_IRQ_MSK, 8'h04);
    settle();
    `CHK("irq", 1'b1, irq_o)
    wr(OFF_IRQ_ST, 8'h04);
    settle();
    `CHK("irq", 1'b0, irq_o)
    node.evt(2);
    rdchk(OFF_REC, 8'h77, "rec");
    `CHK("passive", 1'b0, err_passive_o)
    complete_run();
  end
endmodule
bind can_rx_buffer can_rx_buffer_chk chk (.clk_i(clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i),
  .rx_err_small_i(rx_err_small_i), .rx_err_large_i(rx_err_large_i),
  .rx_ok_i(rx_ok_i), .err_passive_o(err_passive_o), .irq_o(irq_o));
